// >>> bya_alu.sv
// combinational result and flag logic for the byte alu
`timescale 1ns/1ns
module bya_alu (
    // operand and result bundle
    bya_alu_if.alu bus
);
    import bya_pkg::*;

    always_comb begin
        logic [8:0] diff;
        logic [4:0] ndiff;
        logic [7:0] a;
        logic [7:0] b;
        logic       cin;
        diff       = 9'h000;
        ndiff      = 5'h00;
        a          = bus.fval;
        b          = bus.wval;
        cin        = 1'b1;
        bus.res    = 8'h00;
        bus.c_out  = bus.c_in;
        bus.dc_out = 1'b0;
        bus.skip   = 1'b0;
        bus.upd_c  = 1'b0;
        bus.upd_dc = 1'b0;
        bus.upd_z  = 1'b0;
        case (bus.op)
            OP_DECREMENT_SKIP_ZERO: begin
                bus.res  = bus.fval - 8'h01;
                bus.skip = (bus.res == 8'h00);
            end
            OP_INCREMENT_SKIP_ZERO: begin
                bus.res  = bus.fval + 8'h01;
                bus.skip = (bus.res == 8'h00);
            end
            OP_OR_LITERAL_INTO_ACC: begin
                bus.res   = bus.wval | bus.lit;
                bus.upd_z = 1'b1;
            end
            OP_INCREMENT_FILE: begin
                bus.res   = bus.fval + 8'h01;
                bus.upd_z = 1'b1;
            end
            OP_OR_ACC_WITH_FILE: begin
                bus.res   = bus.wval | bus.fval;
                bus.upd_z = 1'b1;
            end
            OP_ROTATE_RIGHT_VIA_CARRY: begin
                bus.res   = {bus.c_in, bus.fval[7:1]};
                bus.c_out = bus.fval[0];
                bus.upd_c = 1'b1;
            end
            OP_SUBTRACT_ACC_FROM_LITERAL,
            OP_SUBTRACT_ACC_FROM_FILE,
            OP_SUBTRACT_ACC_BORROW_FROM_FILE: begin
                if (bus.op == OP_SUBTRACT_ACC_FROM_LITERAL) begin
                    a = bus.lit;
                end
                if (bus.op == OP_SUBTRACT_ACC_BORROW_FROM_FILE) begin
                    cin = bus.c_in;
                end
                // two's complement: a + ~b + carry-in
                diff       = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
                ndiff      = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
                bus.res    = diff[7:0];
                bus.c_out  = diff[8];
                bus.dc_out = ndiff[4];
                bus.upd_c  = 1'b1;
                bus.upd_dc = 1'b1;
                bus.upd_z  = 1'b1;
            end
            default: begin
                bus.res = 8'h00;
            end
        endcase
        bus.z_out = (bus.res == 8'h00);
    end
endmodule : bya_alu

// >>> bya_alu_if.sv
// operands and results between core and alu
`timescale 1ns/1ns
interface bya_alu_if;
    bya_pkg::bya_op_t op;
    logic [7:0]       fval;
    logic [7:0]       wval;
    logic [7:0]       lit;
    logic             c_in;
    logic [7:0]       res;
    logic             c_out;
    logic             dc_out;
    logic             z_out;
    logic             skip;
    logic             upd_c;
    logic             upd_dc;
    logic             upd_z;
    modport alu  (input op, fval, wval, lit, c_in,
                  output res, c_out, dc_out, z_out, skip, upd_c, upd_dc, upd_z);
    modport core (output op, fval, wval, lit, c_in,
                  input res, c_out, dc_out, z_out, skip, upd_c, upd_dc, upd_z);
endinterface : bya_alu_if

// >>> bya_file_ram.sv
// file register storage, one write port and two read ports
`timescale 1ns/1ns
module bya_file_ram #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8,
    parameter int AW    = 7
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // read ports
    input  wire logic [AW-1:0]    raddr_a,
    output logic      [WIDTH-1:0] rdata_a,
    input  wire logic [AW-1:0]    raddr_b,
    output logic      [WIDTH-1:0] rdata_b
);
    logic [WIDTH-1:0] mem_reg  [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];

    always_comb begin
        mem_next = mem_reg;
        if (we) begin
            mem_next[waddr] = wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_reg <= '{default: '0};
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rdata_a = mem_reg[raddr_a];
    assign rdata_b = mem_reg[raddr_b];
endmodule : bya_file_ram

// >>> bya_pkg.sv
// types shared by the byte alu modules
package bya_pkg;
    typedef enum logic [3:0] {
        OP_DECREMENT_SKIP_ZERO        = 4'h0,
        OP_INCREMENT_SKIP_ZERO        = 4'h1,
        OP_JUMP_ABSOLUTE              = 4'h2,
        OP_OR_LITERAL_INTO_ACC        = 4'h3,
        OP_INCREMENT_FILE             = 4'h4,
        OP_OR_ACC_WITH_FILE           = 4'h5,
        OP_ROTATE_RIGHT_VIA_CARRY     = 4'h6,
        OP_SUBTRACT_ACC_FROM_LITERAL  = 4'h7,
        OP_SUBTRACT_ACC_FROM_FILE     = 4'h8,
        OP_SUBTRACT_ACC_BORROW_FROM_FILE = 4'h9,
        OP_SLEEP                      = 4'hA
    } bya_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_NOP   = 2'b10,
        ST_SLEEP = 2'b11
    } bya_state_t;
endpackage : bya_pkg

// >>> bya_regs.svh
// register map, field positions, reset values and widths for the byte alu
//
// Summary of operation
// - file operand 0..127 plus one destination bit
// - destination bit 0 writes acc, 1 writes file
// - decrement file, skip next when zero
// - increment file, skip next when zero
// - jump loads low eleven pc bits, upper latch
// - jump takes two instruction cycles
// - or literal into acc, zero flag only
// - increment file to destination, zero flag only
// - or acc with file, zero flag only
// - rotate file right through carry, carry only
// - literal minus acc, carry nibble zero flags
// - file minus acc to destination, three flags
// - file minus acc minus inverted carry, flags
// - sleep clears watchdog, sets expiry, clears powerdown
`ifndef BYA_REGS_SVH
`define BYA_REGS_SVH

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define BYA_OFF_INSTR      12'h000
`define BYA_OFF_ACC        12'h004
`define BYA_OFF_STATUS     12'h008
`define BYA_OFF_PC         12'h00C
`define BYA_OFF_PC_LATCH   12'h010
`define BYA_OFF_EXEC       12'h014
`define BYA_OFF_WDT        12'h018
`define BYA_FILE_BASE_HI   3'h1

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BYA_OP_LSB         16
`define BYA_DEST_BIT       7
`define BYA_C_BIT          0
`define BYA_DC_BIT         1
`define BYA_Z_BIT          2
`define BYA_PD_BIT         3
`define BYA_TO_BIT         4
`define BYA_EXEC_WAKE_BIT  0

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define BYA_STATUS_RST     5'h18
`define BYA_PC_W           15
`define BYA_INSTR_W        20

`endif

// >>> bya_top.sv
// byte alu instruction subset with axi4-lite register access
`timescale 1ns/1ns
`include "bya_regs.svh"
module bya_top #(
    parameter int ADDR_W = 12,
    parameter int PRE_W  = 7,
    parameter int WDT_W  = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address and data
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import bya_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bya_state_t              state_reg,   state_next;
    logic [`BYA_INSTR_W-1:0] instr_reg,   instr_next;
    logic [7:0]              acc_reg,     acc_next;
    logic [4:0]              status_reg,  status_next;
    logic [`BYA_PC_W-1:0]    pc_reg,      pc_next;
    logic [6:0]              pc_latch_reg, pc_latch_next;
    logic [PRE_W-1:0]        pre_reg,     pre_next;
    logic [WDT_W-1:0]        wdt_reg,     wdt_next;
    logic                    skip_reg,    skip_next;

    logic              awready_reg, awready_next;
    logic              wready_reg,  wready_next;
    logic              aw_have_reg, aw_have_next;
    logic              w_have_reg,  w_have_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [31:0]       wdata_reg,   wdata_next;
    logic [3:0]        wstrb_reg,   wstrb_next;
    logic              bvalid_reg,  bvalid_next;
    logic [1:0]        bresp_reg,   bresp_next;
    logic              arready_reg, arready_next;
    logic              rvalid_reg,  rvalid_next;
    logic [31:0]       rdata_reg,   rdata_next;
    logic [1:0]        rresp_reg,   rresp_next;

    // ------------------------------------------------------------------
    // alu and file registers
    // ------------------------------------------------------------------
    bya_alu_if alu_bus ();

    logic       ram_we;
    logic [6:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_fval;
    logic [7:0] ram_rd;

    bya_alu u_alu (
        .bus (alu_bus.alu)
    );

    bya_file_ram #(
        .DEPTH (128),
        .WIDTH (8),
        .AW    (7)
    ) u_file (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (ram_we),
        .waddr   (ram_waddr),
        .wdata   (ram_wdata),
        .raddr_a (instr_reg[6:0]),
        .rdata_a (ram_fval),
        .raddr_b (s_axi_araddr[8:2]),
        .rdata_b (ram_rd)
    );

    bya_op_t op;
    logic    dest_file;
    assign op        = bya_op_t'(instr_reg[`BYA_OP_LSB +: 4]);
    assign dest_file = instr_reg[`BYA_DEST_BIT];

    assign alu_bus.op   = op;
    assign alu_bus.fval = ram_fval;
    assign alu_bus.wval = acc_reg;
    assign alu_bus.lit  = instr_reg[7:0];
    assign alu_bus.c_in = status_reg[`BYA_C_BIT];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic              wr_commit;
    logic              ar_fire;
    logic [31:0]       wmask;
    assign wa        = {aw_addr_reg[ADDR_W-1:2], 2'b00};
    assign ra        = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    assign wr_commit = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign ar_fire   = s_axi_arvalid & arready_reg;
    assign wmask     = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    always_comb begin
        aw_have_next = aw_have_reg | (s_axi_awvalid & awready_reg);
        w_have_next  = w_have_reg | (s_axi_wvalid & wready_reg);
        aw_addr_next = (s_axi_awvalid & awready_reg) ? s_axi_awaddr : aw_addr_reg;
        wdata_next   = (s_axi_wvalid & wready_reg) ? s_axi_wdata : wdata_reg;
        wstrb_next   = (s_axi_wvalid & wready_reg) ? s_axi_wstrb : wstrb_reg;
        bvalid_next  = bvalid_reg & ~s_axi_bready;
        bresp_next   = bresp_reg;
        if (wr_commit) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = 2'b00;
            if (wa[ADDR_W-1:9] != `BYA_FILE_BASE_HI && wa != `BYA_OFF_INSTR &&
                wa != `BYA_OFF_ACC && wa != `BYA_OFF_STATUS && wa != `BYA_OFF_PC &&
                wa != `BYA_OFF_PC_LATCH && wa != `BYA_OFF_EXEC && wa != `BYA_OFF_WDT) begin
                bresp_next = 2'b10;
            end
        end
        awready_next = ~aw_have_next & ~bvalid_next;
        wready_next  = ~w_have_next & ~bvalid_next;

        rvalid_next  = ar_fire | (rvalid_reg & ~s_axi_rready);
        arready_next = ~rvalid_next;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (ar_fire) begin
            rresp_next = 2'b00;
            rdata_next = 32'h0000_0000;
            if (ra[ADDR_W-1:9] == `BYA_FILE_BASE_HI) begin
                rdata_next = {24'h00_0000, ram_rd};
            end else begin
                case (ra)
                    `BYA_OFF_INSTR:    rdata_next = {12'h000, instr_reg};
                    `BYA_OFF_ACC:      rdata_next = {24'h00_0000, acc_reg};
                    `BYA_OFF_STATUS:   rdata_next = {27'h000_0000, status_reg};
                    `BYA_OFF_PC:       rdata_next = {17'h0_0000, pc_reg};
                    `BYA_OFF_PC_LATCH: rdata_next = {25'h000_0000, pc_latch_reg};
                    `BYA_OFF_EXEC: begin
                        rdata_next = {29'h0000_0000, skip_reg, state_reg == ST_SLEEP,
                                      state_reg == ST_EXEC || state_reg == ST_NOP};
                    end
                    `BYA_OFF_WDT: rdata_next = {{(32-WDT_W){1'b0}}, wdt_reg};
                    default:      rresp_next = 2'b10;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // instruction execution
    // ------------------------------------------------------------------
    logic wr_ok;
    assign wr_ok = wr_commit & (bresp_next == 2'b00);

    always_comb begin
        logic [7:0] res;
        res           = alu_bus.res;
        state_next    = state_reg;
        instr_next    = instr_reg;
        acc_next      = acc_reg;
        status_next   = status_reg;
        pc_next       = pc_reg;
        pc_latch_next = pc_latch_reg;
        skip_next     = skip_reg;
        pre_next      = pre_reg;
        wdt_next      = wdt_reg;
        ram_we        = 1'b0;
        ram_waddr     = instr_reg[6:0];
        ram_wdata     = res;

        // software access to architectural state
        if (wr_ok && wstrb_reg[0]) begin
            if (wa == `BYA_OFF_ACC) begin
                acc_next = wdata_reg[7:0];
            end
            if (wa == `BYA_OFF_STATUS) begin
                status_next = wdata_reg[4:0];
            end
            if (wa == `BYA_OFF_PC_LATCH) begin
                pc_latch_next = wdata_reg[6:0];
            end
            if (wa[ADDR_W-1:9] == `BYA_FILE_BASE_HI) begin
                ram_we    = 1'b1;
                ram_waddr = wa[8:2];
                ram_wdata = wdata_reg[7:0];
            end
        end

        // watchdog runs while the oscillator runs
        if (state_reg != ST_SLEEP) begin
            pre_next = pre_reg + 1'b1;
            if (pre_reg == {PRE_W{1'b1}}) begin
                wdt_next = wdt_reg + 1'b1;
                if (wdt_reg == {WDT_W{1'b1}}) begin
                    status_next[`BYA_TO_BIT] = 1'b0;
                end
            end
        end

        case (state_reg)
            ST_IDLE: begin
                if (wr_ok && wa == `BYA_OFF_INSTR) begin
                    instr_next = (instr_reg & ~wmask[`BYA_INSTR_W-1:0]) |
                                 (wdata_reg[`BYA_INSTR_W-1:0] & wmask[`BYA_INSTR_W-1:0]);
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
                pc_next    = pc_reg + 15'h0001;
                skip_next  = alu_bus.skip;
                case (op)
                    OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_FILE,
                    OP_OR_ACC_WITH_FILE, OP_ROTATE_RIGHT_VIA_CARRY,
                    OP_SUBTRACT_ACC_FROM_FILE, OP_SUBTRACT_ACC_BORROW_FROM_FILE: begin
                        if (dest_file) begin
                            ram_we    = 1'b1;
                            ram_waddr = instr_reg[6:0];
                            ram_wdata = res;
                        end else begin
                            acc_next = res;
                        end
                    end
                    OP_OR_LITERAL_INTO_ACC, OP_SUBTRACT_ACC_FROM_LITERAL: begin
                        acc_next = res;
                    end
                    OP_JUMP_ABSOLUTE: begin
                        pc_next    = {pc_latch_reg[6:3], instr_reg[10:0]};
                        state_next = ST_NOP;
                    end
                    OP_SLEEP: begin
                        pre_next                 = {PRE_W{1'b0}};
                        wdt_next                 = {WDT_W{1'b0}};
                        status_next[`BYA_TO_BIT] = 1'b1;
                        status_next[`BYA_PD_BIT] = 1'b0;
                        state_next               = ST_SLEEP;
                    end
                    default: begin
                        pc_next = pc_reg + 15'h0001;
                    end
                endcase
                if (alu_bus.upd_c) begin
                    status_next[`BYA_C_BIT] = alu_bus.c_out;
                end
                if (alu_bus.upd_dc) begin
                    status_next[`BYA_DC_BIT] = alu_bus.dc_out;
                end
                if (alu_bus.upd_z) begin
                    status_next[`BYA_Z_BIT] = alu_bus.z_out;
                end
                if (alu_bus.skip) begin
                    pc_next    = pc_reg + 15'h0002;
                    state_next = ST_NOP;
                end
            end
            ST_NOP: begin
                state_next = ST_IDLE;
            end
            ST_SLEEP: begin
                if (wr_ok && wa == `BYA_OFF_EXEC && wdata_reg[`BYA_EXEC_WAKE_BIT]) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= ST_IDLE;
            instr_reg    <= '0;
            acc_reg      <= 8'h00;
            status_reg   <= `BYA_STATUS_RST;
            pc_reg       <= '0;
            pc_latch_reg <= 7'h00;
            pre_reg      <= '0;
            wdt_reg      <= '0;
            skip_reg     <= 1'b0;
            awready_reg  <= 1'b0;
            wready_reg   <= 1'b0;
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            aw_addr_reg  <= '0;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= 2'b00;
            arready_reg  <= 1'b0;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            rresp_reg    <= 2'b00;
        end else begin
            state_reg    <= state_next;
            instr_reg    <= instr_next;
            acc_reg      <= acc_next;
            status_reg   <= status_next;
            pc_reg       <= pc_next;
            pc_latch_reg <= pc_latch_next;
            pre_reg      <= pre_next;
            wdt_reg      <= wdt_next;
            skip_reg     <= skip_next;
            awready_reg  <= awready_next;
            wready_reg   <= wready_next;
            aw_have_reg  <= aw_have_next;
            w_have_reg   <= w_have_next;
            aw_addr_reg  <= aw_addr_next;
            wdata_reg    <= wdata_next;
            wstrb_reg    <= wstrb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            arready_reg  <= arready_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
endmodule : bya_top

// >>> bya_top_sva.sv
// bus handshake checks for the byte alu
`timescale 1ns/1ns
module bya_top_sva #(parameter int ADDR_W = 12) (
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // handshakes
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // payloads
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic [1:0]        s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("bad bresp");
    r_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
    r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late rvalid");
    ar_shut_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready open");
    aw_shut_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write open");
    aw_close_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stuck");
    unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h100
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("no slverr");
endmodule : bya_top_sva
bind bya_top bya_top_sva #(.ADDR_W(ADDR_W)) i_bya_top_sva (.*);

// >>> bya_top_tb_top.sv
// self-checking bench for the byte alu
`timescale 1ns/1ns
module bya_top_tb_top;
    logic        aclk = 0, aresetn = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          bad_count = 0, samples_checked = 0;
    bya_top i_bya_top (.*);
    initial forever #20 aclk = ~aclk;
    task print_verdict;
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        bad_count += (g !== e);
        if (g !== e) $display("[FAIL] %s expected %h seen %h", nm, e, g);
    endtask : chk
    // one transfer; readys sampled on the low phase, acted on at the edge
    task automatic bus(input logic [11:0] a, input logic [31:0] d, input bit w = 1'b1);
        logic p1, p2, ok = 0;
        int n = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        while (!ok && n < 64) begin
            @(negedge aclk);
            {ok, v, rs} = w ? {s_axi_bvalid, 32'h0, s_axi_bresp} :
                              {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            {p1, p2} = {w ? s_axi_awready : s_axi_arready, s_axi_wready};
            @(posedge aclk);
            if (p1) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (p2) s_axi_wvalid <= 1'b0;
            n++;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        bad_count += (n >= 64);
        if (n >= 64) print_verdict();
    endtask : bus
    task rc(input logic [11:0] a, input logic [31:0] e);
        bus(a, 32'h0, 1'b0);
        chk($sformatf("reg %h", a), e, v);
    endtask : rc
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        bus(12'h214, 32'h1);
        bus(12'h000, 32'h00085);
        rc(12'h214, 32'h0);
        rc(12'h00C, 32'h2);
        bus(12'h014, 32'h0, 1'b0);
        chk("skipped", 32'h1, v[2]);
        bus(12'h000, 32'h10005);
        rc(12'h004, 32'h1);
        rc(12'h00C, 32'h3);
        bus(12'h218, 32'hFF);
        bus(12'h000, 32'h40086);
        rc(12'h218, 32'h0);
        rc(12'h008, 32'h1C);
        bus(12'h000, 32'h30081);
        rc(12'h004, 32'h81);
        rc(12'h008, 32'h18);
        bus(12'h214, 32'h12);
        bus(12'h000, 32'h50085);
        rc(12'h214, 32'h93);
        bus(12'h008, 32'h19);
        bus(12'h000, 32'h60086);
        rc(12'h218, 32'h80);
        rc(12'h008, 32'h18);
        bus(12'h21C, 32'h10);
        bus(12'h004, 32'h1);
        bus(12'h000, 32'h80087);
        rc(12'h21C, 32'h0F);
        rc(12'h008, 32'h19);
        bus(12'h000, 32'h70001);
        rc(12'h008, 32'h1F);
        bus(12'h008, 32'h18);
        bus(12'h000, 32'h90007);
        rc(12'h004, 32'h0E);
        rc(12'h008, 32'h1B);
        bus(12'h010, 32'h28);
        bus(12'h000, 32'h207FF);
        rc(12'h00C, 32'h2FFF);
        bus(12'h008, 32'h08);
        bus(12'h000, 32'hA0000);
        rc(12'h008, 32'h10);
        rc(12'h018, 32'h0);
        bus(12'h014, 32'h0, 1'b0);
        chk("asleep", 32'h1, v[1]);
        bus(12'h014, 32'h1);
        bus(12'h100, 32'h5A);
        chk("unmapped bresp", 32'h2, rs);
        bus(12'h100, 32'h0, 1'b0);
        chk("unmapped rresp", 32'h2, rs);
        print_verdict();
    end
endmodule : bya_top_tb_top
